/* File: core/gpib_pkg.sv */
// package: bus line indices, command codes and buffer sizes for the bus port
package gpib_pkg;
	// widths of the bus byte, the command code and the device address
	localparam int DATA_W  = 8;
	localparam int CODE_W  = 7;
	localparam int ADDR_W  = 5;
	localparam int LINE_W  = 3;

	// synchronised pin vector: eight data lines then four control lines
	localparam int PINS_W  = 12;
	localparam int PIN_ATN = 8;
	localparam int PIN_EOI = 9;
	localparam int PIN_IFC = 10;
	localparam int PIN_REN = 11;
	// idle level of every pin (all lines released, electrically high)
	localparam logic [PINS_W-1:0] PINS_IDLE = 12'hFFF;

	// received-byte buffer: eight data bits plus the end marker
	localparam int FIFO_W     = 9;
	localparam int FIFO_DEPTH = 16;

	// group field of a command byte, taken from code bits five and six
	localparam int GRP_MSB = 6;
	localparam int GRP_LSB = 5;
	localparam logic [1:0] GRP_CMD    = 2'h0;
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK   = 2'h2;
	localparam logic [1:0] GRP_SECOND = 2'h3;

	// interface command codes (seven bits, eighth bit already dropped)
	localparam logic [CODE_W-1:0] CMD_GO_LOCAL   = 7'h01;
	localparam logic [CODE_W-1:0] CMD_SEL_CLEAR  = 7'h04;
	localparam logic [CODE_W-1:0] CMD_PP_CONFIG  = 7'h05;
	localparam logic [CODE_W-1:0] CMD_TRIGGER    = 7'h08;
	localparam logic [CODE_W-1:0] CMD_DEV_CLEAR  = 7'h14;
	localparam logic [CODE_W-1:0] CMD_PP_UNCONF  = 7'h15;
	localparam logic [CODE_W-1:0] CMD_SPOLL_ON   = 7'h18;
	localparam logic [CODE_W-1:0] CMD_SPOLL_OFF  = 7'h19;
	localparam logic [CODE_W-1:0] CMD_UNLISTEN   = 7'h3F;
	localparam logic [CODE_W-1:0] CMD_UNTALK     = 7'h5F;

	// parallel-poll enable byte of the secondary group: bit four set disables
	localparam int PP_OFF_BIT = 4;
	localparam int PP_LINE_LSB = 0;
endpackage

/* File: core/line_sync.sv */
// two-stage synchroniser for a vector of asynchronous bus lines
`timescale 1ns/1ns
module line_sync
	import gpib_pkg::*;
#(
	parameter int               WIDTH = PINS_W,
	parameter logic [WIDTH-1:0] IDLE  = PINS_IDLE
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	// first stage is read only by the second stage
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta   <= IDLE;
			sync_o <= IDLE;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule

/* File: core/byte_fifo.sv */
// small first-in first-out buffer with a registered output stage
`timescale 1ns/1ns
module byte_fifo
	import gpib_pkg::*;
#(
	parameter int WIDTH = FIFO_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = PTR_W + 1;
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic             wr;
	logic             rd;

	// a write needs room; a read refills the output stage when it frees up
	always_comb begin
		wr = in_valid_i && in_ready_o;
		rd = (count != '0) && (!out_valid_o || out_ready_i);
		next_count = count;
		if (wr && !rd) begin
			next_count = count + CNT_ONE;
		end else if (rd && !wr) begin
			next_count = count - CNT_ONE;
		end
	end

	// storage has no reset, only the pointers do
	always_ff @(posedge clk_i) begin
		if (wr) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// pointers and fill level; ready is registered from the next level
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_ptr     <= '0;
			rd_ptr     <= '0;
			count      <= '0;
			in_ready_o <= 1'b0;
		end else begin
			if (wr) begin
				wr_ptr <= wr_ptr + PTR_W'(1);
			end
			if (rd) begin
				rd_ptr <= rd_ptr + PTR_W'(1);
			end
			count      <= next_count;
			in_ready_o <= (next_count != CNT_FULL);
		end
	end

	// output stage holds its word until the consumer takes it
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end else if (rd) begin
			out_valid_o <= 1'b1;
			out_data_o  <= mem[rd_ptr];
		end else if (out_ready_i) begin
			out_valid_o <= 1'b0;
		end
	end
endmodule

/* File: core/gpib_poll_address_control.sv */
// bus port: addressing, command decode, parallel poll and data buffering
`timescale 1ns/1ns
module gpib_poll_address_control
	import gpib_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	// bus pins, electrically low-true
	input  wire logic [DATA_W-1:0] dio_n_i,
	output logic      [DATA_W-1:0] dio_n_o,
	output logic      [DATA_W-1:0] dio_oe_n_o,
	input  wire logic              atn_n_i,
	input  wire logic              eoi_n_i,
	output logic                   eoi_n_o,
	output logic                   eoi_oe_n_o,
	input  wire logic              ifc_n_i,
	input  wire logic              ren_n_i,
	// byte strobe from the handshake logic on this clock
	input  wire logic              byte_stb_i,
	output logic                   byte_ready_o,
	// configuration
	input  wire logic [ADDR_W-1:0] my_addr_i,
	input  wire logic              ext_en_i,
	input  wire logic [ADDR_W-1:0] sec_addr_i,
	input  wire logic              rsv_i,
	// received data bytes
	output logic                   rx_valid_o,
	output logic      [DATA_W-1:0] rx_data_o,
	output logic                   rx_end_o,
	input  wire logic              rx_ready_i,
	// byte to send while talker
	input  wire logic              tx_load_i,
	input  wire logic [DATA_W-1:0] tx_data_i,
	input  wire logic              tx_last_i,
	input  wire logic              tx_sent_i,
	output logic                   tx_empty_o,
	// status
	output logic                   listener_o,
	output logic                   talker_o,
	output logic                   remote_o,
	output logic                   spoll_mode_o,
	output logic                   dev_clear_o,
	output logic                   trigger_o,
	output logic                   ifc_event_o
);
	typedef enum logic [1:0] {
		prim_none,
		prim_listen,
		prim_talk,
		prim_ppc
	} prim_t;

	logic [PINS_W-1:0] pins;
	logic [DATA_W-1:0] bus_byte;
	logic              atn;
	logic              eoi;
	logic              ifc;
	logic              ren;
	logic              ifc_d;
	logic              poll_active;
	logic              cmd_stb;
	logic              data_stb;
	logic              data_wr;
	logic [CODE_W-1:0] code;
	logic [1:0]        grp;
	logic              own_addr;
	logic              own_sec;
	logic              listen_hit;
	logic              talk_hit;
	logic              listen_first;
	logic              talk_first;
	prim_t             prim;
	prim_t             next_prim;
	logic              ppoll_en;
	logic [LINE_W-1:0] ppoll_line;
	logic              tx_full;
	logic [DATA_W-1:0] tx_data;
	logic              tx_last;
	logic              fifo_in_ready;
	logic              fifo_valid;
	logic [FIFO_W-1:0] fifo_data;
	logic [DATA_W-1:0] next_dio_oe_n;
	logic              next_eoi_oe_n;

	// every pin passes two flops before any logic sees it
	line_sync #(
		.WIDTH (PINS_W),
		.IDLE  (PINS_IDLE)
	) u_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.async_i ({ren_n_i, ifc_n_i, eoi_n_i, atn_n_i, dio_n_i}),
		.sync_o  (pins)
	);

	// lines are low-true on the wire; flip them once here
	assign bus_byte = ~pins[DATA_W-1:0];
	assign atn      = ~pins[PIN_ATN];
	assign eoi      = ~pins[PIN_EOI];
	assign ifc      = ~pins[PIN_IFC];
	assign ren      = ~pins[PIN_REN];

	// a poll runs only while both end and attention are held
	assign poll_active = atn && eoi;

	// bytes taken under attention are commands, others are data
	assign cmd_stb  = byte_stb_i && atn && !ifc;
	assign data_stb = byte_stb_i && !atn;
	assign data_wr  = data_stb && listener_o;
	assign code     = bus_byte[CODE_W-1:0];
	assign grp      = code[GRP_MSB:GRP_LSB];
	assign own_addr = (code[ADDR_W-1:0] == my_addr_i);
	assign own_sec  = (code[ADDR_W-1:0] == sec_addr_i);

	// own primary address: direct hit unless an extended second byte follows
	assign listen_first = cmd_stb && (grp == GRP_LISTEN) &&
		(code != CMD_UNLISTEN) && own_addr;
	assign talk_first = cmd_stb && (grp == GRP_TALK) &&
		(code != CMD_UNTALK) && own_addr;
	assign listen_hit = (listen_first && !ext_en_i) ||
		(cmd_stb && (grp == GRP_SECOND) && (prim == prim_listen) &&
		own_sec);
	assign talk_hit = (talk_first && !ext_en_i) ||
		(cmd_stb && (grp == GRP_SECOND) && (prim == prim_talk) &&
		own_sec);

	// remember what the last primary byte was, for a following secondary
	always_comb begin
		next_prim = prim_none;
		case (grp)
			GRP_LISTEN: begin
				if (listen_first && ext_en_i) begin
					next_prim = prim_listen;
				end
			end
			GRP_TALK: begin
				if (talk_first && ext_en_i) begin
					next_prim = prim_talk;
				end
			end
			GRP_CMD: begin
				if (code == CMD_PP_CONFIG && listener_o) begin
					next_prim = prim_ppc;
				end
			end
			default: begin
				next_prim = prim_none;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || ifc) begin
			prim <= prim_none;
		end else if (cmd_stb) begin
			prim <= next_prim;
		end
	end

	// listener state; interface clear wins over everything, even brief ones
	always_ff @(posedge clk_i) begin
		if (reset_i || ifc) begin
			listener_o <= 1'b0;
		end else if (listen_hit) begin
			listener_o <= 1'b1;
		end else if (cmd_stb && code == CMD_UNLISTEN) begin
			listener_o <= 1'b0;
		end
	end

	// talker state; any other talk address unaddresses us
	always_ff @(posedge clk_i) begin
		if (reset_i || ifc) begin
			talker_o <= 1'b0;
		end else if (talk_hit) begin
			talker_o <= 1'b1;
		end else if (cmd_stb && code == CMD_UNTALK) begin
			talker_o <= 1'b0;
		end else if (cmd_stb && grp == GRP_TALK && !own_addr) begin
			talker_o <= 1'b0;
		end
	end

	// remote needs remote-enable held first, then our listen address
	always_ff @(posedge clk_i) begin
		if (reset_i || !ren) begin
			remote_o <= 1'b0;
		end else if (listen_hit) begin
			remote_o <= 1'b1;
		end else if (cmd_stb && code == CMD_GO_LOCAL && listener_o) begin
			remote_o <= 1'b0;
		end
	end

	// parallel-poll line assignment from the enable byte after configure
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ppoll_en   <= 1'b0;
			ppoll_line <= '0;
		end else if (cmd_stb && code == CMD_PP_UNCONF) begin
			ppoll_en <= 1'b0;
		end else if (cmd_stb && grp == GRP_SECOND && prim == prim_ppc) begin
			ppoll_en   <= !code[PP_OFF_BIT];
			ppoll_line <= code[PP_LINE_LSB +: LINE_W];
		end
	end

	// serial-poll mode from the universal enable and disable codes
	always_ff @(posedge clk_i) begin
		if (reset_i || ifc) begin
			spoll_mode_o <= 1'b0;
		end else if (cmd_stb && code == CMD_SPOLL_OFF) begin
			spoll_mode_o <= 1'b0;
		end else if (cmd_stb && code == CMD_SPOLL_ON) begin
			spoll_mode_o <= 1'b1;
		end
	end

	// one-cycle event pulses for clears, trigger and interface clear;
	// the synchroniser resets to idle, so no false clear edge follows reset
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			dev_clear_o <= 1'b0;
			trigger_o   <= 1'b0;
			ifc_d       <= 1'b0;
			ifc_event_o <= 1'b0;
		end else begin
			dev_clear_o <= cmd_stb && ((code == CMD_DEV_CLEAR) ||
				(code == CMD_SEL_CLEAR && listener_o));
			trigger_o   <= cmd_stb && code == CMD_TRIGGER && listener_o;
			ifc_d       <= ifc;
			ifc_event_o <= ifc && !ifc_d;
		end
	end

	// outgoing byte waits here until the handshake reports it sent
	always_ff @(posedge clk_i) begin
		if (reset_i || ifc) begin
			tx_full <= 1'b0;
			tx_data <= '0;
			tx_last <= 1'b0;
		end else if (!tx_full && tx_load_i) begin
			tx_full <= 1'b1;
			tx_data <= tx_data_i;
			tx_last <= tx_last_i;
		end else if (tx_sent_i) begin
			tx_full <= 1'b0;
		end
	end

	// pin drive: poll answer under attention with end, talker data without attention;
	// lines are open-drain so a shared poll line just reads low
	always_comb begin
		next_dio_oe_n = '1;
		next_eoi_oe_n = 1'b1;
		if (poll_active) begin
			if (ppoll_en && rsv_i) begin
				next_dio_oe_n[ppoll_line] = 1'b0;
			end
		end else if (talker_o && !atn && !ifc && tx_full) begin
			next_dio_oe_n = ~tx_data;
			next_eoi_oe_n = !tx_last;
		end
	end

	// drive registers; released one edge after the two-flop sync delay once a poll ends
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			dio_oe_n_o <= '1;
			eoi_oe_n_o <= 1'b1;
		end else begin
			dio_oe_n_o <= next_dio_oe_n;
			eoi_oe_n_o <= next_eoi_oe_n;
		end
	end

	// driven level is always low; only the enables move
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			dio_n_o <= '0;
			eoi_n_o <= 1'b0;
		end else begin
			dio_n_o <= '0;
			eoi_n_o <= 1'b0;
		end
	end

	// status flags that only mirror internal state
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tx_empty_o   <= 1'b1;
			byte_ready_o <= 1'b0;
		end else begin
			tx_empty_o   <= !(tx_full || (!tx_full && tx_load_i));
			// the buffer's own ready lags a write by one edge, so a byte
			// taken now holds ready low for one edge; this halves the
			// peak rate but a strobe never lands on a full buffer
			byte_ready_o <= fifo_in_ready && !data_wr;
		end
	end

	// data bytes for us go in unchanged, end line kept as a marker
	byte_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.in_valid_i  (data_wr),
		.in_data_i   ({eoi, bus_byte}),
		.in_ready_o  (fifo_in_ready),
		.out_valid_o (fifo_valid),
		.out_data_o  (fifo_data),
		.out_ready_i (rx_ready_i)
	);

	// fifo output stage is already a register, copied straight out
	assign rx_valid_o = fifo_valid;
	assign rx_data_o  = fifo_data[DATA_W-1:0];
	assign rx_end_o   = fifo_data[DATA_W];
endmodule

/* File: verification/gpib_poll_address_control_props.sv */
// checker: port timing of the bus port
`timescale 1ns/1ns
module gpib_poll_address_control_props
	import gpib_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire logic [DATA_W-1:0] dio_oe_n_o,
	input  wire logic              atn_n_i,
	input  wire logic              eoi_n_i,
	input  wire logic              eoi_oe_n_o,
	input  wire logic              ifc_n_i,
	input  wire logic              ren_n_i,
	input  wire logic              byte_stb_i,
	input  wire logic              rx_valid_o,
	input  wire logic [DATA_W-1:0] rx_data_o,
	input  wire logic              rx_end_o,
	input  wire logic              rx_ready_i,
	input  wire logic              listener_o,
	input  wire logic              talker_o,
	input  wire logic              remote_o,
	input  wire logic              ifc_event_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// clear seen low on two samples, long enough to cross the synchroniser
	sequence s_ifc_fall;
		$fell(ifc_n_i) ##1 !ifc_n_i;
	endsequence
	// attention without end: command mode, never a poll
	sequence s_atn_only;
		(!atn_n_i && eoi_n_i) [*5];
	endsequence
	AST_IFC_IDLE: assert property (
		s_ifc_fall |-> ##3 (!listener_o && !talker_o))
		else $error("clear left an addressed state");
	AST_IFC_EVENT: assert property (
		s_ifc_fall |-> ##[1:4] ifc_event_o)
		else $error("short clear not reported");
	AST_POLL_STOP: assert property (s_atn_only |-> dio_oe_n_o == 8'hFF)
		else $error("data line driven outside a poll");
	AST_EOI_QUIET: assert property ((!atn_n_i) [*5] |-> eoi_oe_n_o)
		else $error("end line driven during attention");
	AST_REMOTE_REN: assert property (ren_n_i [*4] |=> !remote_o)
		else $error("remote kept without remote enable");
	AST_LISTEN_CMD: assert property (
		$rose(listener_o) |-> $past(byte_stb_i) && !$past(atn_n_i, 3))
		else $error("listener set without a command byte");
	AST_TALK_CMD: assert property ($rose(talker_o) |-> $past(byte_stb_i))
		else $error("talker set without a byte");
	AST_RX_HOLD: assert property (
		rx_valid_o && !rx_ready_i |=>
		rx_valid_o && $stable(rx_data_o) && $stable(rx_end_o))
		else $error("received byte changed while stalled");
endmodule

bind gpib_poll_address_control gpib_poll_address_control_props
	gpib_poll_address_control_props_inst (
	.clk_i(clk_i), .reset_i(reset_i), .dio_oe_n_o(dio_oe_n_o),
	.atn_n_i(atn_n_i), .eoi_n_i(eoi_n_i), .eoi_oe_n_o(eoi_oe_n_o),
	.ifc_n_i(ifc_n_i), .ren_n_i(ren_n_i), .byte_stb_i(byte_stb_i),
	.rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_end_o(rx_end_o),
	.rx_ready_i(rx_ready_i), .listener_o(listener_o), .talker_o(talker_o),
	.remote_o(remote_o), .ifc_event_o(ifc_event_o));

/* File: verification/bus_ctrl_model.sv */
// behavioural bus controller: drives control and data lines, strobes bytes
`timescale 1ns/1ns
module bus_ctrl_model
	import gpib_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic [DATA_W-1:0] dio_n_i,
	output logic      [DATA_W-1:0] dio_n_o,
	output logic                   atn_n_o,
	output logic                   eoi_n_o,
	output logic                   ifc_n_o,
	output logic                   ren_n_o,
	output logic                   byte_stb_o
);
	// all lines released at start; terminators pull them high
	initial begin
		dio_n_o = 8'hFF;
		{atn_n_o, eoi_n_o, ifc_n_o, ren_n_o, byte_stb_o} = 5'h1E;
	end
	// one byte, settling 2 to 5 cycles before the strobe, then released
	task automatic xfer(input logic a, input logic [DATA_W-1:0] d,
		input logic last, input int gap);
		@(negedge clk_i);
		atn_n_o = ~a;
		dio_n_o = ~d;
		eoi_n_o = ~last;
		repeat (2 + gap) @(negedge clk_i);
		byte_stb_o = 1'b1;
		@(negedge clk_i);
		byte_stb_o = 1'b0;
		dio_n_o = 8'hFF;
		eoi_n_o = 1'b1;
	endtask
	// attention and remote enable levels
	task automatic lines(input logic a_n, input logic r_n);
		@(negedge clk_i);
		atn_n_o = a_n;
		ren_n_o = r_n;
	endtask
	// poll: end with attention, read the wired lines, then drop end
	task automatic poll(output logic [DATA_W-1:0] seen);
		@(negedge clk_i);
		atn_n_o = 1'b0;
		eoi_n_o = 1'b0;
		repeat (5) @(negedge clk_i);
		seen = dio_n_i;
		eoi_n_o = 1'b1;
		repeat (5) @(negedge clk_i);
	endtask
	// clear pulse of n cycles, as short as a power-on blip may be
	task automatic clear(input int n);
		@(negedge clk_i);
		ifc_n_o = 1'b0;
		repeat (n) @(negedge clk_i);
		ifc_n_o = 1'b1;
		repeat (4) @(negedge clk_i);
	endtask
endmodule

/* File: verification/gpib_poll_address_control_tb.sv */
// testbench: controller model on the bus, random consumer on the stream
`timescale 1ns/1ns
module gpib_poll_address_control_tb
	import gpib_pkg::*;
;
	logic              clk_i = 1'b0;
	logic              reset_i = 1'b1;
	logic              rsv = 1'b0;
	logic              rx_ready = 1'b0;
	logic              hold = 1'b0;
	logic              tx_load = 1'b0;
	logic              tx_last = 1'b0;
	logic              tx_sent = 1'b0;
	logic              ext_en = 1'b0;
	logic [ADDR_W-1:0] addr = 5'h00;
	logic [ADDR_W-1:0] sec = 5'h00;
	logic [DATA_W-1:0] tx_data = 8'h00;
	logic [DATA_W-1:0] b, seen, ctl_dio, dio_n, dio_oe_n, dio_bus, rx_data;
	logic [3:0]        pulses = 4'h0;
	logic              atn, eoi_c, eoi_n, eoi_oe_n, eoi_bus, ifc, ren, stb;
	logic              rdy, rx_valid, rx_end, tx_empty, lis, tlk, rem;
	logic              spoll, dclr, trig, ifcev;
	logic [8:0]        exp_q[$];
	int                seed = 67, err_count = 0, n_checks = 0;
	int                cycles = 0, i, n;

	// 10 MHz clock
	always #50 clk_i = ~clk_i;
	// open-drain lines: any party pulling low wins
	assign dio_bus = ctl_dio & (dio_n | dio_oe_n);
	assign eoi_bus = eoi_c & (eoi_n | eoi_oe_n);

	gpib_poll_address_control gpib_poll_address_control_inst (
		.clk_i(clk_i), .reset_i(reset_i), .dio_n_i(dio_bus),
		.dio_n_o(dio_n), .dio_oe_n_o(dio_oe_n), .atn_n_i(atn),
		.eoi_n_i(eoi_bus), .eoi_n_o(eoi_n), .eoi_oe_n_o(eoi_oe_n),
		.ifc_n_i(ifc), .ren_n_i(ren), .byte_stb_i(stb), .byte_ready_o(rdy),
		.my_addr_i(addr), .ext_en_i(ext_en), .sec_addr_i(sec), .rsv_i(rsv),
		.rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_end_o(rx_end),
		.rx_ready_i(rx_ready), .tx_load_i(tx_load), .tx_data_i(tx_data),
		.tx_last_i(tx_last), .tx_sent_i(tx_sent), .tx_empty_o(tx_empty),
		.listener_o(lis), .talker_o(tlk), .remote_o(rem),
		.spoll_mode_o(spoll), .dev_clear_o(dclr), .trigger_o(trig),
		.ifc_event_o(ifcev));
	bus_ctrl_model bus_ctrl_model_inst (.clk_i(clk_i), .dio_n_i(dio_bus),
		.dio_n_o(ctl_dio), .atn_n_o(atn), .eoi_n_o(eoi_c), .ifc_n_o(ifc),
		.ren_n_o(ren), .byte_stb_o(stb));

	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cmd(input logic [DATA_W-1:0] c);
		bus_ctrl_model_inst.xfer(1'b1, c, 1'b0, $random(seed) & 3);
	endtask
	// data byte; only sent while the device should keep it, so noted first
	task automatic dat(input logic [DATA_W-1:0] d, input logic last);
		exp_q.push_back({last, d});
		bus_ctrl_model_inst.xfer(1'b0, d, last, $random(seed) & 3);
	endtask

	// consumer with random stalls, held off while the buffer is filled
	always @(negedge clk_i) begin
		rx_ready <= !hold && ($random(seed) & 1);
	end
	// each byte taken is matched to the oldest note; none left means extra
	always @(posedge clk_i) begin
		if (!reset_i && rx_valid && rx_ready) begin
			if (exp_q.size() == 0) exp_q.push_back('x);
			chk({rx_end, rx_data}, exp_q.pop_front());
		end
	end
	// pulse tally and hang guard; the sequence needs about 600 cycles
	always @(posedge clk_i) begin
		// outputs are unknown before the first reset edge
		if (!reset_i) begin
			pulses <= pulses + 4'(trig) + 4'(dclr) + 4'(ifcev);
		end
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			err_count++;
			wrap_up();
		end
	end

	initial begin
		addr = 5'($unsigned($random(seed)) % 31);
		repeat (2) @(negedge clk_i);
		reset_i = 1'b0;
		repeat (3) @(negedge clk_i);
		chk({tx_empty, dio_oe_n}, 9'h1FF);
		// remote enable first, then the listen address with bit eight set
		bus_ctrl_model_inst.lines(1'b1, 1'b0);
		cmd(8'hA0 | addr);
		chk(lis, 1'b1);
		chk(rem, 1'b1);
		// data bytes, one carrying the unlisten code, last with the end line
		for (i = 0; i < 4; i++) begin
			b = (i == 1) ? {1'b0, CMD_UNLISTEN} : DATA_W'($random(seed));
			dat(b, i == 3);
		end
		chk(lis, 1'b1);
		// fill the buffer with the consumer stalled until it refuses
		while (exp_q.size() != 0) begin
			@(negedge clk_i);
		end
		hold = 1'b1;
		n = 0;
		repeat (3) @(negedge clk_i);
		while (rdy === 1'b1 && n < 40) begin
			dat(DATA_W'($random(seed)), 1'b0);
			repeat (2) @(negedge clk_i);
			n++;
		end
		// sixteen stored words plus the one held in the output register
		chk(9'(n), 9'(FIFO_DEPTH + 1));
		hold = 1'b0;
		while (exp_q.size() != 0) begin
			@(negedge clk_i);
		end
		repeat (4) @(negedge clk_i);
		chk(rx_valid, 1'b0);
		cmd({1'b0, CMD_UNLISTEN});
		chk(lis, 1'b0);
		// a data byte while unaddressed must never reach the stream
		b = DATA_W'($random(seed));
		bus_ctrl_model_inst.xfer(1'b0, b, 1'b0, 0);
		repeat (4) @(negedge clk_i);
		chk(rx_valid, 1'b0);
		bus_ctrl_model_inst.lines(1'b1, 1'b1);
		repeat (5) @(negedge clk_i);
		chk(rem, 1'b0);
		// each poll line in turn, polled once with service wanted
		cmd(8'h20 | addr);
		rsv = 1'b1;
		for (i = 0; i < 8; i++) begin
			cmd({1'b0, CMD_PP_CONFIG});
			cmd(8'h60 + 8'(i));
			bus_ctrl_model_inst.poll(seen);
			chk(seen, 8'(~(8'h01 << i)));
		end
		rsv = 1'b0;
		bus_ctrl_model_inst.poll(seen);
		chk(seen, 8'hFF);
		rsv = 1'b1;
		cmd({1'b0, CMD_PP_UNCONF});
		bus_ctrl_model_inst.poll(seen);
		chk(seen, 8'hFF);
		// talker drives byte and end marker once attention is released
		cmd(8'h40 | addr);
		chk(tlk, 1'b1);
		tx_data = DATA_W'($random(seed));
		tx_last = 1'b1;
		tx_load = 1'b1;
		@(negedge clk_i);
		tx_load = 1'b0;
		bus_ctrl_model_inst.lines(1'b1, 1'b1);
		repeat (5) @(negedge clk_i);
		chk({eoi_bus, dio_bus}, {~tx_last, ~tx_data});
		tx_sent = 1'b1;
		@(negedge clk_i);
		tx_sent = 1'b0;
		repeat (2) @(negedge clk_i);
		chk({tx_empty, dio_oe_n}, 9'h1FF);
		cmd(8'h40 | 8'((addr + 1) % 31));
		chk(tlk, 1'b0);
		cmd(8'h40 | addr);
		cmd({1'b0, CMD_UNTALK});
		chk(tlk, 1'b0);
		// extended talk address: the primary byte alone is not enough
		ext_en = 1'b1;
		sec = 5'($unsigned($random(seed)));
		cmd(8'h40 | addr);
		chk(tlk, 1'b0);
		cmd(8'h60 | sec);
		chk(tlk, 1'b1);
		ext_en = 1'b0;
		cmd({1'b0, CMD_SPOLL_ON});
		chk(spoll, 1'b1);
		cmd({1'b0, CMD_SPOLL_OFF});
		chk(spoll, 1'b0);
		cmd({1'b0, CMD_SPOLL_ON});
		cmd({1'b0, CMD_TRIGGER});
		cmd({1'b0, CMD_DEV_CLEAR});
		// short clear with the device addressed both ways
		cmd(8'h40 | addr);
		bus_ctrl_model_inst.clear(2);
		chk({lis, tlk, spoll}, 9'h000);
		chk(pulses, 9'h003);
		wrap_up();
	end
endmodule
